// ### hdl/ms_protect_1n.sv
// 1:n linear multiplex-section protection: selector, bridge, protection trail
// termination pass-through and APS insert/extract adaptation, with a register port.
// assumes all streams share line_ck and frame_start, both from outside this clock domain.
//
// The strobed register port and the register offsets are this design's own decisions.
`timescale 1ns/100ps

// What this block does
// - select working or protection per normal output
// - working outputs always bridged from normal inputs
// - protection output: none, extra, or normal
// - unfed protection output carries null signal
// - on switch extra output forced all-ones
// - one protection for up to fourteen, revertive
// - type and restore changes only while idle
// - hold restore wait before reverting
// - lockout, forced, manual, clear, exercise; fail, degrade
// - trail source passes stream unchanged
// - trail fail follows server fail, gated cause
// - insert APS bits with section data
// - extract K1 and first five K2 bits
// - accept APS after three identical frames
// - APS extraction only on protection section
module ms_protect_1n #(
  parameter int N_WORK = mslp_pkg::MAX_WORK,
  parameter int TICK_CYCLES = mslp_pkg::TICK_CYCLES,
  parameter logic [15:0] K1_INDEX = mslp_pkg::K1_INDEX,
  parameter logic [15:0] K2_INDEX = mslp_pkg::K2_INDEX
) (
  // clock and reset
  input  wire logic                                   clock,
  input  wire logic                                   rst_n,
  // line timing
  input  wire logic                                   line_ck,
  input  wire logic                                   frame_start,
  // sink direction inputs
  input  wire logic [N_WORK-1:0][mslp_pkg::DATA_W-1:0] work_rx_data,
  input  wire logic [N_WORK-1:0]                      work_trail_fail,
  input  wire logic [N_WORK-1:0]                      work_trail_degrade,
  input  wire logic [mslp_pkg::DATA_W-1:0]            prot_rx_data,
  input  wire logic                                   prot_trail_fail,
  input  wire logic                                   prot_trail_degrade,
  // source direction inputs
  input  wire logic [N_WORK-1:0][mslp_pkg::DATA_W-1:0] norm_tx_data,
  input  wire logic [mslp_pkg::DATA_W-1:0]            extra_tx_data,
  // sink direction outputs
  output logic [N_WORK-1:0][mslp_pkg::DATA_W-1:0]      norm_rx_data,
  output logic [N_WORK-1:0]                           norm_server_fail,
  output logic [mslp_pkg::DATA_W-1:0]                 extra_rx_data,
  output logic                                        extra_server_fail,
  output logic                                        trail_fail_action,
  output logic                                        server_fail_cause,
  output logic                                        protocol_failure_cause,
  // source direction outputs
  output logic [N_WORK-1:0][mslp_pkg::DATA_W-1:0]      work_tx_data,
  output logic [mslp_pkg::DATA_W-1:0]                 prot_tx_data,
  output logic                                        out_strobe,
  output logic                                        out_frame_start,
  // register port
  input  wire logic [mslp_pkg::ADDR_W-1:0]            reg_addr,
  input  wire logic [31:0]                            reg_wr_data,
  input  wire logic                                   reg_wr,
  input  wire logic                                   reg_rd,
  output logic [31:0]                                 reg_rd_data,
  output logic                                        irq
);
  import mslp_pkg::*;

  localparam int TW = $clog2(TICK_CYCLES);
  localparam logic [CH_W-1:0] N_CH = CH_W'(N_WORK);

  typedef logic [N_WORK-1:0][DATA_W-1:0] bus_t;

  typedef struct packed {
    logic ck1, ck2, ck3, fs1, fs2;
    bus_t wd1, wd2, nt1, nt2, norm_rx, work_tx;
    logic [DATA_W-1:0] pd1, pd2, et1, et2, prot_tx, extra_rx, pattern, k1_tmp;
    logic [N_WORK-1:0] wf1, wf2, wsd1, wsd2, norm_fail;
    logic pf1, pf2, psd1, psd2;
    logic [15:0] byte_cnt;
    logic [APS_W-1:0] aps_cand, aps_acc;
    logic [1:0] aps_cnt;
    logic bidir_cfg, bidir_eff, extra_sel, report_en;
    logic [1:0] null_mode;
    logic [WTR_W-1:0] wtr_cfg, wtr_eff, wtr_cnt;
    logic [2:0] cmd;
    logic [CH_W-1:0] cmd_ch, sel_ch, wtr_ch, tx_ch;
    logic [3:0] sel_code, tx_req;
    logic [TW-1:0] tick_cnt;
    logic [IRQ_W-1:0] istat, imask;
    logic extra_fail, tfa, cause, fop, strobe, ofs;
    logic [31:0] rd_data;
  } state_t;

  state_t s_r, s_nxt;

  // lowest-numbered section with its bit set, zero when none
  function automatic logic [CH_W-1:0] first_set(input logic [N_WORK-1:0] v);
    logic [CH_W-1:0] ch;
    ch = '0;
    for (int i = N_WORK - 1; i >= 0; i--) begin
      if (v[i]) begin
        ch = CH_W'(i + 1);
      end
    end
    return ch;
  endfunction

  logic             lk_edge;
  logic [3:0]       lreq, creq;
  logic [CH_W-1:0]  lch, cch, lf, ld;
  logic             below;
  logic             tick;
  logic [APS_W-1:0] aps_tx, frame_aps;
  logic [DATA_W-1:0] src;
  logic [1:0]       cnt_nxt;
  logic [IRQ_W-1:0] ev;

  always_comb begin
    s_nxt = s_r;
    // two-stage synchronisers; the first stage feeds only the second
    s_nxt.ck1 = line_ck;
    s_nxt.ck2 = s_r.ck1;
    s_nxt.ck3 = s_r.ck2;
    s_nxt.fs1 = frame_start;
    s_nxt.fs2 = s_r.fs1;
    s_nxt.wd1 = work_rx_data;
    s_nxt.wd2 = s_r.wd1;
    s_nxt.nt1 = norm_tx_data;
    s_nxt.nt2 = s_r.nt1;
    s_nxt.pd1 = prot_rx_data;
    s_nxt.pd2 = s_r.pd1;
    s_nxt.et1 = extra_tx_data;
    s_nxt.et2 = s_r.et1;
    s_nxt.wf1 = work_trail_fail;
    s_nxt.wf2 = s_r.wf1;
    s_nxt.wsd1 = work_trail_degrade;
    s_nxt.wsd2 = s_r.wsd1;
    s_nxt.pf1 = prot_trail_fail;
    s_nxt.pf2 = s_r.pf1;
    s_nxt.psd1 = prot_trail_degrade;
    s_nxt.psd2 = s_r.psd1;
    lk_edge = s_r.ck2 & ~s_r.ck3;
    ev = '0;

    // local request, highest priority first
    lf = first_set(s_r.wf2);
    ld = first_set(s_r.wsd2);
    below = 1'b0;
    lch = '0;
    if (s_r.cmd == CMD_LOCK) begin
      lreq = REQ_LO;
    end else if (s_r.pf2) begin
      lreq = REQ_SF;
    end else if (s_r.cmd == CMD_FORCE) begin
      lreq = REQ_FS;
      lch = s_r.cmd_ch;
    end else if (lf != '0) begin
      lreq = REQ_SF;
      lch = lf;
    end else if (ld != '0) begin
      lreq = REQ_SD;
      lch = ld;
    end else if (s_r.psd2) begin
      lreq = REQ_SD;
    end else if (s_r.cmd == CMD_MAN) begin
      lreq = REQ_MS;
      lch = s_r.cmd_ch;
    end else begin
      below = 1'b1;
      if (s_r.wtr_ch != '0) begin
        lreq = REQ_WTR;
        lch = s_r.wtr_ch;
      end else if (s_r.sel_ch != '0 &&
                   (s_r.sel_code == REQ_SF || s_r.sel_code == REQ_SD)) begin
        // keep the selection up in the cycle the restore wait is loaded
        lreq = REQ_WTR;
        lch = s_r.sel_ch;
      end else if (s_r.cmd == CMD_EXER) begin
        lreq = REQ_EXER;
        lch = s_r.cmd_ch;
      end else begin
        lreq = REQ_NR;
      end
    end

    // wait-to-restore: revertive only, so a cleared working fail or degrade goes through it when nothing higher is up
    tick = (s_r.tick_cnt == TW'(TICK_CYCLES - 1));
    s_nxt.tick_cnt = tick ? '0 : s_r.tick_cnt + TW'(1);
    if (below && s_r.wtr_ch == '0 && s_r.sel_ch != '0 &&
        (s_r.sel_code == REQ_SF || s_r.sel_code == REQ_SD)) begin
      s_nxt.wtr_ch = s_r.sel_ch;
      s_nxt.wtr_cnt = s_r.wtr_eff;
    end else if (!below || (reg_wr_data[2:0] == CMD_CLEAR && s_r.wtr_ch != '0 && reg_wr &&
                            reg_addr == A_CMD)) begin
      s_nxt.wtr_ch = '0;
    end else if (s_r.wtr_ch != '0 && tick) begin
      if (s_r.wtr_cnt == '0) begin
        s_nxt.wtr_ch = '0;
      end else begin
        s_nxt.wtr_cnt = s_r.wtr_cnt - WTR_W'(1);
      end
    end

    // bidirectional: a higher far-end request steers the selector too
    creq = lreq;
    cch = lch;
    if (s_r.bidir_eff && s_r.aps_acc[12:9] > lreq) begin
      creq = s_r.aps_acc[12:9];
      cch = s_r.aps_acc[8:5];
    end
    if (creq == REQ_LO || creq == REQ_EXER || creq == REQ_NR || cch > N_CH) begin
      s_nxt.sel_ch = '0;
    end else begin
      s_nxt.sel_ch = cch;
    end
    s_nxt.sel_code = creq;
    s_nxt.tx_req = lreq;
    s_nxt.tx_ch = lch;
    if (s_nxt.sel_ch != s_r.sel_ch) begin
      ev[IRQ_SWITCH] = 1'b1;
    end

    // configuration takes effect only while nothing is switched or requested
    if (s_r.sel_ch == '0 && lreq == REQ_NR && s_r.wtr_ch == '0) begin
      s_nxt.bidir_eff = s_r.bidir_cfg;
      s_nxt.wtr_eff = s_r.wtr_cfg;
    end
    // far end claiming a 1+1 architecture while we run bidirectional 1:n
    s_nxt.fop = s_r.bidir_eff & s_r.aps_acc[0];
    if (s_nxt.fop & ~s_r.fop) begin
      ev[IRQ_FOP] = 1'b1;
    end

    // protection trail termination sink
    s_nxt.tfa = s_r.pf2;
    s_nxt.cause = s_r.pf2 & s_r.report_en;

    aps_tx = {s_r.tx_req, s_r.tx_ch, s_r.sel_ch, 1'b0};
    frame_aps = {s_r.k1_tmp, s_r.pd2[7:3]};
    cnt_nxt = 2'h1;
    if (frame_aps == s_r.aps_cand) begin
      cnt_nxt = (s_r.aps_cnt == APS_ACCEPT) ? APS_ACCEPT : s_r.aps_cnt + 2'h1;
    end
    s_nxt.strobe = 1'b0;
    s_nxt.ofs = s_r.ofs;
    if (lk_edge) begin
      s_nxt.strobe = 1'b1;
      s_nxt.ofs = s_r.fs2;
      s_nxt.byte_cnt = s_r.fs2 ? '0 : s_r.byte_cnt + 16'h0001;
      s_nxt.pattern = s_r.pattern + 8'h01;
      // K bytes are taken only from the protection section
      if (s_nxt.byte_cnt == K1_INDEX) begin
        s_nxt.k1_tmp = s_r.pd2;
      end
      if (s_nxt.byte_cnt == K2_INDEX) begin
        s_nxt.aps_cand = frame_aps;
        s_nxt.aps_cnt = cnt_nxt;
        if (cnt_nxt == APS_ACCEPT && frame_aps != s_r.aps_acc) begin
          s_nxt.aps_acc = frame_aps;
          ev[IRQ_APS] = 1'b1;
        end
      end
      for (int i = 0; i < N_WORK; i++) begin
        s_nxt.work_tx[i] = s_r.nt2[i];
        if (s_r.sel_ch == CH_W'(i + 1)) begin
          s_nxt.norm_rx[i] = s_r.pd2;
          s_nxt.norm_fail[i] = s_r.pf2;
        end else begin
          s_nxt.norm_rx[i] = s_r.wd2[i];
          s_nxt.norm_fail[i] = s_r.wf2[i];
        end
      end
      // extra traffic loses the protection section on any switch
      if (s_r.sel_ch != '0 || !s_r.extra_sel) begin
        s_nxt.extra_rx = 8'hFF;
        s_nxt.extra_fail = 1'b1;
      end else begin
        s_nxt.extra_rx = s_r.pd2;
        s_nxt.extra_fail = s_r.pf2;
      end
      // bridge source for the protection output
      if (s_r.sel_ch != '0) begin
        src = s_r.nt2[s_r.sel_ch - CH_W'(1)];
      end else if (s_r.extra_sel) begin
        src = s_r.et2;
      end else if (s_r.null_mode == NULL_NORM1) begin
        src = s_r.nt2[0];
      end else if (s_r.null_mode == NULL_TEST) begin
        src = s_r.pattern;
      end else begin
        src = 8'hFF;
      end
      if (s_nxt.byte_cnt == K1_INDEX) begin
        s_nxt.prot_tx = aps_tx[12:5];
      end else if (s_nxt.byte_cnt == K2_INDEX) begin
        s_nxt.prot_tx = {aps_tx[4:0], src[2:0]};
      end else begin
        s_nxt.prot_tx = src;
      end
    end else begin
      src = '0;
    end

    // register port
    s_nxt.rd_data = '0;
    if (reg_rd) begin
      case (reg_addr)
        A_CTRL: s_nxt.rd_data = {28'h0, s_r.null_mode, s_r.extra_sel, s_r.bidir_cfg};
        A_WTR: s_nxt.rd_data = {22'h0, s_r.wtr_cfg};
        A_CMD: s_nxt.rd_data = {24'h0, s_r.cmd_ch, 1'b0, s_r.cmd};
        A_STATUS: s_nxt.rd_data = {22'h0, s_r.pf2, s_r.wtr_ch != '0, s_r.tx_req, s_r.sel_ch};
        A_APS_RX: s_nxt.rd_data = {19'h0, s_r.aps_acc};
        A_IRQ_STAT: s_nxt.rd_data = {29'h0, s_r.istat};
        A_IRQ_MASK: s_nxt.rd_data = {29'h0, s_r.imask};
        A_REPORT: s_nxt.rd_data = {31'h0, s_r.report_en};
        default: s_nxt.rd_data = '0;
      endcase
    end
    // write-one-to-clear, a new event in the same cycle wins
    s_nxt.istat = s_r.istat | ev;
    if (reg_wr) begin
      case (reg_addr)
        A_CTRL: begin
          s_nxt.bidir_cfg = reg_wr_data[CTRL_BIDIR];
          s_nxt.extra_sel = reg_wr_data[CTRL_EXTRA];
          s_nxt.null_mode = reg_wr_data[CTRL_NULL+:2];
        end
        A_WTR: begin
          s_nxt.wtr_cfg = (reg_wr_data[WTR_W-1:0] > WTR_MAX_S) ? WTR_MAX_S
                                                               : reg_wr_data[WTR_W-1:0];
        end
        A_CMD: begin
          s_nxt.cmd = reg_wr_data[2:0];
          s_nxt.cmd_ch = reg_wr_data[CMD_CH+:CH_W];
        end
        A_IRQ_STAT: s_nxt.istat = (s_r.istat & ~reg_wr_data[IRQ_W-1:0]) | ev;
        A_IRQ_MASK: s_nxt.imask = reg_wr_data[IRQ_W-1:0];
        A_REPORT: s_nxt.report_en = reg_wr_data[0];
        default: s_nxt.istat = s_r.istat | ev;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s_r <= '0;
      s_r.wtr_cfg <= WTR_RESET_S;
      s_r.wtr_eff <= WTR_RESET_S;
      s_r.null_mode <= NULL_RESET;
      s_r.extra_fail <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign norm_rx_data = s_r.norm_rx;
  assign norm_server_fail = s_r.norm_fail;
  assign extra_rx_data = s_r.extra_rx;
  assign extra_server_fail = s_r.extra_fail;
  assign trail_fail_action = s_r.tfa;
  assign server_fail_cause = s_r.cause;
  assign protocol_failure_cause = s_r.fop;
  assign work_tx_data = s_r.work_tx;
  assign prot_tx_data = s_r.prot_tx;
  assign out_strobe = s_r.strobe;
  assign out_frame_start = s_r.ofs;
  assign reg_rd_data = s_r.rd_data;
  assign irq = |(s_r.istat & s_r.imask);

  a_work_bridge: assert property (@(posedge clock) disable iff (!rst_n)
    (s_r.ck2 && !s_r.ck3) |=> (s_r.work_tx == $past(s_r.nt2)))
    else $error("working output not bridged from normal input");

  a_fail_cause: assert property (@(posedge clock) disable iff (!rst_n)
    ##1 (server_fail_cause == ($past(s_r.pf2) && $past(s_r.report_en))))
    else $error("fail cause not gated by report enable");

  a_aps_accept: assert property (@(posedge clock) disable iff (!rst_n)
    $changed(s_r.aps_acc) |-> (s_r.aps_cnt == APS_ACCEPT && s_r.aps_cand == s_r.aps_acc))
    else $error("APS accepted without three identical frames");

  a_extra_ais: assert property (@(posedge clock) disable iff (!rst_n)
    (s_r.ck2 && !s_r.ck3 && s_r.sel_ch != '0) |=> (extra_rx_data == 8'hFF && extra_server_fail))
    else $error("extra traffic not squelched on switch");

  a_null_ones: assert property (@(posedge clock) disable iff (!rst_n)
    (s_r.ck2 && !s_r.ck3 && s_r.sel_ch == '0 && !s_r.extra_sel && s_r.null_mode == NULL_ONES
     && s_nxt.byte_cnt != K1_INDEX && s_nxt.byte_cnt != K2_INDEX) |=> (prot_tx_data == 8'hFF))
    else $error("null signal not all-ones");

  a_lockout_idle: assert property (@(posedge clock) disable iff (!rst_n)
    (s_r.cmd == CMD_LOCK)[*2] |-> (s_r.sel_ch == '0))
    else $error("lockout did not release protection");

  a_sf_switch: assert property (@(posedge clock) disable iff (!rst_n)
    (s_r.wf2[1:0] == 2'b10 && !s_r.pf2 && s_r.cmd == CMD_CLEAR &&
     !(s_r.bidir_eff && s_r.aps_acc[12:9] > REQ_SF))[*2] |-> (s_r.sel_ch == 4'h2))
    else $error("signal fail on section two not switched");

  a_cfg_quiet: assert property (@(posedge clock) disable iff (!rst_n)
    ($changed(s_r.bidir_eff) || $changed(s_r.wtr_eff)) |-> ($past(s_r.sel_ch) == '0))
    else $error("configuration changed while switched");

  a_wtr_load: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(s_r.wtr_ch != '0) |-> (s_r.wtr_cnt == s_r.wtr_eff && s_r.sel_ch == s_r.wtr_ch))
    else $error("restore wait not loaded from setting");

  a_k1_insert: assert property (@(posedge clock) disable iff (!rst_n)
    (s_r.ck2 && !s_r.ck3 && s_nxt.byte_cnt == K1_INDEX) |=> (prot_tx_data == $past(aps_tx[12:5])))
    else $error("K1 not inserted on protection output");
endmodule

// ### common/mslp_pkg.sv
// constants for the 1:n multiplex-section linear protection block
// assumes one byte-wide stream per section, all sharing one line clock and frame start
package mslp_pkg;
  localparam int DATA_W = 8;
  localparam int CH_W = 4;
  localparam int MAX_WORK = 14;
  localparam int APS_W = 13;
  localparam int ADDR_W = 4;
  localparam int IRQ_W = 3;
  localparam int WTR_W = 10;
  // request codes, numeric order is priority order
  localparam logic [3:0] REQ_LO = 4'hF;
  localparam logic [3:0] REQ_FS = 4'hE;
  localparam logic [3:0] REQ_SF = 4'hD;
  localparam logic [3:0] REQ_SD = 4'hB;
  localparam logic [3:0] REQ_MS = 4'h8;
  localparam logic [3:0] REQ_WTR = 4'h6;
  localparam logic [3:0] REQ_EXER = 4'h4;
  localparam logic [3:0] REQ_NR = 4'h0;
  // external command codes
  localparam logic [2:0] CMD_CLEAR = 3'h0;
  localparam logic [2:0] CMD_LOCK = 3'h1;
  localparam logic [2:0] CMD_FORCE = 3'h2;
  localparam logic [2:0] CMD_MAN = 3'h3;
  localparam logic [2:0] CMD_EXER = 3'h4;
  // null signal modes
  localparam logic [1:0] NULL_ONES = 2'h0;
  localparam logic [1:0] NULL_NORM1 = 2'h1;
  localparam logic [1:0] NULL_TEST = 2'h2;
  // register offsets (word index)
  localparam logic [3:0] A_CTRL = 4'h0;
  localparam logic [3:0] A_WTR = 4'h1;
  localparam logic [3:0] A_CMD = 4'h2;
  localparam logic [3:0] A_STATUS = 4'h3;
  localparam logic [3:0] A_APS_RX = 4'h4;
  localparam logic [3:0] A_IRQ_STAT = 4'h5;
  localparam logic [3:0] A_IRQ_MASK = 4'h6;
  localparam logic [3:0] A_REPORT = 4'h7;
  // field positions
  localparam int CTRL_BIDIR = 0;
  localparam int CTRL_EXTRA = 1;
  localparam int CTRL_NULL = 2;
  localparam int CMD_CH = 4;
  localparam int ST_REQ = 4;
  localparam int ST_WTR = 8;
  localparam int ST_PFAIL = 9;
  localparam int IRQ_APS = 0;
  localparam int IRQ_SWITCH = 1;
  localparam int IRQ_FOP = 2;
  // reset values
  localparam logic [WTR_W-1:0] WTR_RESET_S = 10'h12C;
  localparam logic [1:0] NULL_RESET = NULL_ONES;
  // timing
  localparam int CLOCK_HZ = 25_000_000;
  localparam int TICK_S = 1;
  localparam int TICK_CYCLES = CLOCK_HZ * TICK_S;
  localparam int WTR_MAX_MIN = 12;
  localparam logic [WTR_W-1:0] WTR_MAX_S = WTR_W'(WTR_MAX_MIN * 60);
  localparam logic [1:0] APS_ACCEPT = 2'h3;
  localparam logic [15:0] K1_INDEX = 16'h0010;
  localparam logic [15:0] K2_INDEX = 16'h0011;
endpackage

// ### verification/far_end_model.sv
// far-side stream source: line clock, frame start, working and protection bytes
// assumes the bench sets aps_word between frames and drives the fail lines itself
`timescale 1ns/100ps
module far_end_model #(
  parameter int N     = 4,
  parameter int FRAME = 8,
  parameter int K1_AT = 2,
  parameter int K2_AT = 3
) (
  // switching word to send
  input  wire logic [12:0]  aps_word,
  // line stream
  output logic              line_ck,
  output logic              frame_start,
  output logic [N-1:0][7:0] work_rx_data,
  output logic [7:0]        prot_rx_data
);
  int byte_i;

  // a line clock runs free; frames follow back to back
  initial begin
    line_ck = 1'b0;
    byte_i = 0;
    frame_start = 1'b1;
    prot_rx_data = 8'h5C;
    for (int i = 0; i < N; i++) begin
      work_rx_data[i] = 8'(8'hA0 + i);
    end
    #7;
    forever #160 line_ck = ~line_ck;
  end

  // bytes change mid-period, away from the rising edge the block samples
  always @(negedge line_ck) begin
    byte_i = (byte_i == FRAME - 1) ? 0 : byte_i + 1;
    frame_start <= (byte_i == 0);
    if (byte_i == K1_AT) begin
      prot_rx_data <= aps_word[12:5];
    end else if (byte_i == K2_AT) begin
      prot_rx_data <= {aps_word[4:0], 3'h0};
    end else begin
      prot_rx_data <= 8'h5C;
    end
  end
endmodule

// ### verification/ms_protect_1n_tb_top.sv
// bench for the 1:n protection block: streams, selector, commands, switching word
// assumes far_end_model makes the line clock; registers reached by the plain port
`timescale 1ns/100ps
module ms_protect_1n_tb_top;
  import mslp_pkg::*;
  localparam int N = 4;
  logic                     clock, rst_n, line_ck, frame_start, irq;
  logic [N-1:0][DATA_W-1:0] work_rx_data, norm_tx_data, norm_rx_data, work_tx_data;
  logic [N-1:0]             work_trail_fail, work_trail_degrade, norm_server_fail;
  logic [DATA_W-1:0]        prot_rx_data, extra_tx_data, extra_rx_data, prot_tx_data;
  logic                     prot_trail_fail, prot_trail_degrade, extra_server_fail;
  logic                     trail_fail_action, server_fail_cause, protocol_failure_cause;
  logic                     out_strobe, out_frame_start, reg_wr, reg_rd;
  logic [ADDR_W-1:0]        reg_addr;
  logic [31:0]              reg_wr_data, reg_rd_data, rdv;
  logic [12:0]              aps_word;
  int                       failures, samples_checked;

  far_end_model #(.N(N)) far (.aps_word(aps_word),
    .line_ck(line_ck), .frame_start(frame_start), .work_rx_data(work_rx_data),
    .prot_rx_data(prot_rx_data));

  // short counts keep the restore wait at 200 clocks a "second" of 10
  ms_protect_1n #(.N_WORK(N), .TICK_CYCLES(10), .K1_INDEX(16'h0002), .K2_INDEX(16'h0003)) DUT (
    .clock(clock), .rst_n(rst_n), .line_ck(line_ck), .frame_start(frame_start),
    .work_rx_data(work_rx_data), .work_trail_fail(work_trail_fail),
    .work_trail_degrade(work_trail_degrade), .prot_rx_data(prot_rx_data),
    .prot_trail_fail(prot_trail_fail), .prot_trail_degrade(prot_trail_degrade),
    .norm_tx_data(norm_tx_data), .extra_tx_data(extra_tx_data),
    .norm_rx_data(norm_rx_data), .norm_server_fail(norm_server_fail),
    .extra_rx_data(extra_rx_data), .extra_server_fail(extra_server_fail),
    .trail_fail_action(trail_fail_action), .server_fail_cause(server_fail_cause),
    .protocol_failure_cause(protocol_failure_cause), .work_tx_data(work_tx_data),
    .prot_tx_data(prot_tx_data), .out_strobe(out_strobe),
    .out_frame_start(out_frame_start), .reg_addr(reg_addr), .reg_wr_data(reg_wr_data),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rd_data(reg_rd_data), .irq(irq));

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wr_data <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
    @(negedge clock);
  endtask

  task automatic rd(input logic [3:0] a);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(negedge clock);
    rdv = reg_rd_data;
  endtask

  // n output bytes, each a frame's first byte when fs is set
  task automatic wait_byte(input int n, input logic fs);
    int k;
    for (int j = 0; j < n; j++) begin
      k = 0;
      @(negedge clock);
      while (!(out_strobe === 1'b1 && (out_frame_start === 1'b1 || !fs))) begin
        @(negedge clock);
        k++;
        if (k > 200) begin
          failures++;
          report_and_stop();
        end
      end
    end
  endtask

  task automatic t_reset();
    @(negedge clock);
    chk("extra_fail rst", 32'h1, 32'(extra_server_fail));
    chk("irq rst", 32'h0, 32'(irq));
    rd(A_WTR);
    chk("wtr rst", 32'(WTR_RESET_S), rdv);
    rd(4'hC);
    chk("unmapped", 32'h0, rdv);
    wr(A_WTR, 32'h320);
    rd(A_WTR);
    chk("wtr clamp", 32'(WTR_MAX_S), rdv);
    $display("test reset done");
  endtask

  task automatic t_bridge();
    wait_byte(3, 1'b1);
    for (int i = 0; i < N; i++) begin
      chk("work_tx", 32'(8'h70 + i), 32'(work_tx_data[i]));
      chk("norm_rx", 32'(8'hA0 + i), 32'(norm_rx_data[i]));
    end
    chk("prot_tx ones", 32'hFF, 32'(prot_tx_data));
    wr(A_CTRL, 32'h4);
    wait_byte(2, 1'b1);
    chk("prot_tx norm1", 32'h70, 32'(prot_tx_data));
    wr(A_CTRL, 32'h3);
    wr(A_WTR, 32'h14);
    wait_byte(2, 1'b1);
    chk("prot_tx extra", 32'h3E, 32'(prot_tx_data));
    chk("extra_rx", 32'h5C, 32'(extra_rx_data));
    chk("extra_fail", 32'h0, 32'(extra_server_fail));
    chk("norm_rx kept", 32'hA2, 32'(norm_rx_data[2]));
    @(posedge clock) extra_tx_data <= 8'hC1;
    wait_byte(2, 1'b1);
    chk("prot_tx extra2", 32'hC1, 32'(prot_tx_data));
    $display("test bridge done");
  endtask

  task automatic t_switch();
    @(posedge clock) work_trail_fail[1] <= 1'b1;
    wait_byte(2, 1'b1);
    rd(A_STATUS);
    chk("status sf", 32'h0D2, rdv & 32'h3FF);
    chk("norm_rx sel", 32'h5C, 32'(norm_rx_data[1]));
    chk("norm_fail sel", 32'h0, 32'(norm_server_fail[1]));
    chk("extra_rx ais", 32'hFF, 32'(extra_rx_data));
    chk("extra_fail sw", 32'h1, 32'(extra_server_fail));
    chk("prot_tx bridge", 32'h71, 32'(prot_tx_data));
    wait_byte(2, 1'b0);
    chk("k1 sf", 32'hD2, 32'(prot_tx_data));
    @(posedge clock) work_trail_fail[1] <= 1'b0;
    wait_byte(1, 1'b1);
    rd(A_STATUS);
    chk("status wtr", 32'h162, rdv & 32'h3FF);
    wait_byte(5, 1'b1);
    rd(A_STATUS);
    chk("status revert", 32'h0, rdv & 32'h3FF);
    chk("extra_fail back", 32'h0, 32'(extra_server_fail));
    $display("test switch done");
  endtask

  task automatic t_cmd();
    logic [7:0] cmds [5] = '{{4'h3, 1'b0, CMD_FORCE}, {4'h2, 1'b0, CMD_MAN},
      {4'h0, 1'b0, CMD_LOCK}, {4'h1, 1'b0, CMD_EXER}, {4'h0, 1'b0, CMD_CLEAR}};
    logic [7:0] want [5] = '{{REQ_FS, 4'h3}, {REQ_MS, 4'h2}, {REQ_LO, 4'h0},
      {REQ_EXER, 4'h1}, {REQ_NR, 4'h0}};
    logic [7:0] msk;
    for (int k = 0; k < 5; k++) begin
      // exercise signals the section but never switches it
      msk = (want[k][7:4] == REQ_EXER) ? 8'hF0 : 8'hFF;
      wr(A_CMD, 32'(cmds[k]));
      wait_byte(2, 1'b1);
      rd(A_STATUS);
      chk("status cmd", 32'(want[k] & msk), rdv & 32'hFF);
      wait_byte(2, 1'b0);
      chk("k1 cmd", 32'(want[k]), 32'(prot_tx_data));
    end
    $display("test commands done");
  endtask

  task automatic t_aps();
    wr(A_CTRL, 32'h0);
    wr(A_IRQ_STAT, 32'h7);
    wr(A_IRQ_MASK, 32'h0);
    wait_byte(1, 1'b1);
    aps_word = 13'h1235;
    wait_byte(2, 1'b1);
    rd(A_APS_RX);
    chk("aps two frames", 32'h0, rdv);
    wait_byte(1, 1'b1);
    rd(A_APS_RX);
    chk("aps three frames", 32'h1235, rdv);
    chk("irq masked", 32'h0, 32'(irq));
    wr(A_IRQ_MASK, 32'h1);
    chk("irq raised", 32'h1, 32'(irq));
    wr(A_IRQ_STAT, 32'h1);
    chk("irq cleared", 32'h0, 32'(irq));
    chk("fop off", 32'h0, 32'(protocol_failure_cause));
    wr(A_CTRL, 32'h1);
    wait_byte(2, 1'b1);
    chk("fop bidir", 32'h1, 32'(protocol_failure_cause));
    chk("norm_rx far", 32'h5C, 32'(norm_rx_data[0]));
    $display("test aps done");
  endtask

  task automatic t_trail();
    wr(A_REPORT, 32'h0);
    @(posedge clock) prot_trail_fail <= 1'b1;
    repeat (6) @(negedge clock);
    chk("trail_fail", 32'h1, 32'(trail_fail_action));
    chk("cause off", 32'h0, 32'(server_fail_cause));
    wr(A_REPORT, 32'h1);
    repeat (2) @(negedge clock);
    chk("cause on", 32'h1, 32'(server_fail_cause));
    rd(A_STATUS);
    chk("status pfail", 32'h2D0, rdv & 32'h3FF);
    @(posedge clock) prot_trail_fail <= 1'b0;
    work_trail_degrade[0] <= 1'b1;
    wait_byte(2, 1'b1);
    chk("trail_fail off", 32'h0, 32'(trail_fail_action));
    rd(A_STATUS);
    chk("status sd", 32'h0B1, rdv & 32'h3FF);
    chk("norm_rx sd", 32'h5C, 32'(norm_rx_data[0]));
    @(posedge clock) work_trail_degrade[0] <= 1'b0;
    prot_trail_degrade <= 1'b1;
    wait_byte(2, 1'b1);
    rd(A_STATUS);
    chk("status sd prot", 32'h0B0, rdv & 32'h3FF);
    chk("norm_rx back", 32'hA0, 32'(norm_rx_data[0]));
    $display("test trail done");
  endtask

  initial begin
    failures = 0;
    samples_checked = 0;
    rst_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = '0;
    reg_wr_data = '0;
    aps_word = '0;
    work_trail_fail = '0;
    work_trail_degrade = '0;
    prot_trail_fail = 1'b0;
    prot_trail_degrade = 1'b0;
    extra_tx_data = 8'h3E;
    for (int i = 0; i < N; i++) begin
      norm_tx_data[i] = 8'(8'h70 + i);
    end
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    t_reset();
    t_bridge();
    t_switch();
    t_cmd();
    t_aps();
    t_trail();
    report_and_stop();
  end
endmodule
